// >>> include/i2c_led_pkg.sv
// Shared constants and types for the LED driver serial register port
package i2c_led_pkg;
  // Bus timing of the master end
  localparam int SYS_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * SYS_PERIOD_NS);
  localparam logic [7:0] QTR_LAST = 8'(SCL_QTR_CYC - 1);
  localparam logic [7:0] QTR_ZERO = 8'h00;
  localparam logic [7:0] QTR_ONE = 8'h01;
  // Addressing: select pins fill the two low address bits
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h30;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  // Byte framing and reset values
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] BYTE_RELEASED = 8'hFF;
  localparam logic [3:0] LEN_LAST = 4'h0;
  localparam logic [3:0] LEN_NEXT_LAST = 4'h1;

  typedef enum logic [3:0] {
    S_IDLE      = 4'b0000,
    S_ADDR      = 4'b0001,
    S_ADDR_ACK  = 4'b0010,
    S_PTR       = 4'b0011,
    S_PTR_ACK   = 4'b0100,
    S_WDATA     = 4'b0101,
    S_WDATA_ACK = 4'b0110,
    S_RDATA     = 4'b0111,
    S_RACK      = 4'b1000
  } slave_state_t;

  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_START = 2'b01,
    M_BYTE  = 2'b10,
    M_STOP  = 2'b11
  } master_state_t;

  typedef enum logic [2:0] {
    P_ADDRW = 3'b000,
    P_PTR   = 3'b001,
    P_WDATA = 3'b010,
    P_ADDRR = 3'b011,
    P_RDATA = 3'b100
  } master_step_t;
endpackage : i2c_led_pkg

// >>> include/i2c_link_if.sv
// Two-wire link between the bus master end and the LED driver slave end
`timescale 1ns/1ps
interface i2c_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups: low wins whenever any enabled driver pulls low
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
  modport slave (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface : i2c_link_if

// >>> verilog/sync2.sv
// Two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    q_o <= meta_reg;
  end
endmodule : sync2

// >>> verilog/i2c_slave_end.sv
// Slave end of the LED driver serial port: bus protocol on link clock, register strobes on system clock
`timescale 1ns/1ps
// Function
// - Master adds ninth clock pulse for acknowledge
// - Transmitter releases SDA, receiver holds it low
// - Receiver of each byte acknowledges it
// - Master reader ends data with not-acknowledge
// - Address chosen by two select pins
// - Seven address bits, then direction bit
// - Acknowledge only on address match
// - First write byte loads register pointer
// - Following write bytes go to pointed register
// - Pointer advances after each written byte
// - Master ends write with stop
// - Read address acknowledged, pointed register sent
// - Master acknowledge advances pointer, next byte sent
// - Not-acknowledge then stop ends read, SDA released
// - Eight bits per byte, MSB first
// - Start and stop from SDA edges, SCL high
// - SDA change with SCL high aborts transfer
module i2c_slave_end import i2c_led_pkg::*; (
  // Clocks and reset
  input wire logic sys_clk_i,
  input wire logic link_clk_i,
  input wire logic rstn_i,
  // Address select pins
  input wire logic [1:0] addr_sel_i,
  // Two-wire bus
  i2c_link_if.slave bus,
  // Register side
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  // Link domain signals
  logic link_rstn, scl_s, sda_s, scl_d_reg, sda_d_reg, rw_reg, mack_reg, sda_oe_reg;
  logic wr_tgl_reg, rd_tgl_reg, rack_s, rack_d_reg;
  logic [1:0] sel_s;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_reg, ptr_reg, wr_addr_reg, wr_data_reg, rd_addr_reg, rdata_l_reg;
  slave_state_t state_reg;
  // System domain signals
  logic wr_s, rd_s, wr_d_reg, rd_d_reg, rack_tgl_reg;
  logic [7:0] rdata_sys_reg;

  logic start_det, stop_det, scl_rise, scl_fall, byte_done, addr_hit, wr_req, rd_req;
  logic [6:0] own_addr;
  logic [7:0] rd_addr_next;

  // Pins and reset enter the link domain through two flip-flops
  sync2 #(.W(5)) u_pin_sync (
    .clk_i(link_clk_i),
    .d_i({rstn_i, bus.scl, bus.sda, addr_sel_i}),
    .q_o({link_rstn, scl_s, sda_s, sel_s})
  );

  sync2 #(.W(1)) u_rack_sync (.clk_i(link_clk_i), .d_i(rack_tgl_reg), .q_o(rack_s));
  sync2 #(.W(2)) u_req_sync (.clk_i(sys_clk_i), .d_i({wr_tgl_reg, rd_tgl_reg}), .q_o({wr_s, rd_s}));

  // Open drain: only the enable moves, the driven level is always low
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = sda_oe_reg;

  always_ff @(posedge link_clk_i) begin
    if (!link_rstn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign byte_done = scl_fall && (bit_cnt_reg == BYTE_BITS);
  assign own_addr = {SLAVE_ADDR_BASE[6:2], sel_s};
  assign addr_hit = (shift_reg[7:1] == own_addr);
  assign wr_req = (state_reg == S_WDATA) && byte_done && !start_det && !stop_det;
  assign rd_req = !start_det && !stop_det &&
                  (((state_reg == S_ADDR) && byte_done && addr_hit && (shift_reg[0] == DIR_READ)) ||
                   ((state_reg == S_RACK) && scl_rise && !sda_s));
  assign rd_addr_next = (state_reg == S_RACK) ? ptr_reg + PTR_STEP : ptr_reg;

  // Bus protocol engine
  always_ff @(posedge link_clk_i) begin
    if (!link_rstn) begin
      state_reg <= S_IDLE;
      bit_cnt_reg <= BIT_ZERO;
      shift_reg <= PTR_RESET;
      tx_reg <= PTR_RESET;
      ptr_reg <= PTR_RESET;
      rw_reg <= DIR_WRITE;
      mack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      // A repeated start restarts address reception from any state
      state_reg <= S_ADDR;
      bit_cnt_reg <= BIT_ZERO;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      // Stop, or a rising SDA mid-byte, drops the transfer and frees the line
      state_reg <= S_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        S_ADDR, S_PTR, S_WDATA: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + BIT_ONE;
          end else if (byte_done) begin
            bit_cnt_reg <= BIT_ZERO;
            if (state_reg == S_ADDR) begin
              if (addr_hit) begin
                sda_oe_reg <= 1'b1;
                rw_reg <= shift_reg[0];
                state_reg <= S_ADDR_ACK;
              end else begin
                state_reg <= S_IDLE;
              end
            end else if (state_reg == S_PTR) begin
              ptr_reg <= shift_reg;
              sda_oe_reg <= 1'b1;
              state_reg <= S_PTR_ACK;
            end else begin
              sda_oe_reg <= 1'b1;
              state_reg <= S_WDATA_ACK;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg == DIR_READ) begin
              sda_oe_reg <= !rdata_l_reg[7];
              tx_reg <= {rdata_l_reg[6:0], 1'b0};
              bit_cnt_reg <= BIT_ONE;
              state_reg <= S_RDATA;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg <= S_PTR;
            end
          end
        end
        S_PTR_ACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            state_reg <= S_WDATA;
          end
        end
        S_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            ptr_reg <= ptr_reg + PTR_STEP;
            state_reg <= S_WDATA;
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_reg == BYTE_BITS) begin
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= BIT_ZERO;
              state_reg <= S_RACK;
            end else begin
              sda_oe_reg <= !tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + BIT_ONE;
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            mack_reg <= !sda_s;
            if (!sda_s) begin
              ptr_reg <= ptr_reg + PTR_STEP;
            end
          end else if (scl_fall) begin
            if (mack_reg) begin
              sda_oe_reg <= !rdata_l_reg[7];
              tx_reg <= {rdata_l_reg[6:0], 1'b0};
              bit_cnt_reg <= BIT_ONE;
              state_reg <= S_RDATA;
            end else begin
              // Not acknowledged: wait released for the stop
              state_reg <= S_IDLE;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Requests to the system domain; address and data stay put while the toggle crosses
  always_ff @(posedge link_clk_i) begin
    if (!link_rstn) begin
      wr_tgl_reg <= 1'b0;
      rd_tgl_reg <= 1'b0;
      wr_addr_reg <= PTR_RESET;
      wr_data_reg <= PTR_RESET;
      rd_addr_reg <= PTR_RESET;
    end else begin
      if (wr_req) begin
        wr_tgl_reg <= !wr_tgl_reg;
        wr_addr_reg <= ptr_reg;
        wr_data_reg <= shift_reg;
      end
      if (rd_req) begin
        rd_tgl_reg <= !rd_tgl_reg;
        rd_addr_reg <= rd_addr_next;
      end
    end
  end

  // Read data returns on a toggle; the word is stable before the toggle lands
  always_ff @(posedge link_clk_i) begin
    if (!link_rstn) begin
      rack_d_reg <= 1'b0;
      rdata_l_reg <= PTR_RESET;
    end else begin
      rack_d_reg <= rack_s;
      if (rack_s != rack_d_reg) begin
        rdata_l_reg <= rdata_sys_reg;
      end
    end
  end

  // Register strobes on the system clock
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      wr_d_reg <= 1'b0;
      rd_d_reg <= 1'b0;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      reg_addr_o <= PTR_RESET;
      reg_wdata_o <= PTR_RESET;
    end else begin
      wr_d_reg <= wr_s;
      rd_d_reg <= rd_s;
      reg_wr_o <= (wr_s != wr_d_reg);
      reg_rd_o <= (rd_s != rd_d_reg);
      if (wr_s != wr_d_reg) begin
        reg_addr_o <= wr_addr_reg;
        reg_wdata_o <= wr_data_reg;
      end else if (rd_s != rd_d_reg) begin
        reg_addr_o <= rd_addr_reg;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rack_tgl_reg <= 1'b0;
      rdata_sys_reg <= PTR_RESET;
    end else if (reg_rd_o) begin
      rdata_sys_reg <= reg_rdata_i;
      rack_tgl_reg <= !rack_tgl_reg;
    end
  end
endmodule : i2c_slave_end

// >>> verilog/i2c_master_end.sv
// Bus master end: generates the serial clock and runs register write and read transfers
`timescale 1ns/1ps
module i2c_master_end import i2c_led_pkg::*; (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Two-wire bus
  i2c_link_if.master bus,
  // Command
  input wire logic cmd_valid_i,
  input wire logic cmd_read_i,
  input wire logic [1:0] cmd_sel_i,
  input wire logic [7:0] cmd_ptr_i,
  input wire logic [3:0] cmd_len_i,
  output logic cmd_ready_o,
  // Write data
  input wire logic [7:0] tx_data_i,
  output logic tx_take_o,
  // Read data and status
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic done_o,
  output logic nack_o
);
  logic sda_s;
  logic tick;
  logic ack;
  logic [7:0] qcnt_reg;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic [3:0] left_reg;
  logic [8:0] txb_reg;
  logic [8:0] rxb_reg;
  logic read_reg;
  logic [1:0] sel_reg;
  logic [7:0] ptr_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  master_state_t state_reg;
  master_step_t step_reg;

  sync2 #(.W(1)) u_sda_sync (
    .clk_i(sys_clk_i),
    .d_i(bus.sda),
    .q_o(sda_s)
  );

  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_reg;
  assign bus.m_sda_oe = sda_oe_reg;
  assign tick = (qcnt_reg == QTR_LAST);
  assign ack = !rxb_reg[0];

  // Quarter-bit divider derives the serial clock from the system clock
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || state_reg == M_IDLE || tick) begin
      qcnt_reg <= QTR_ZERO;
    end else begin
      qcnt_reg <= qcnt_reg + QTR_ONE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_reg <= M_IDLE;
      step_reg <= P_ADDRW;
      ph_reg <= 2'h0;
      bit_reg <= BIT_ZERO;
      left_reg <= LEN_LAST;
      txb_reg <= 9'h1FF;
      rxb_reg <= 9'h1FF;
      read_reg <= DIR_WRITE;
      sel_reg <= 2'h0;
      ptr_reg <= PTR_RESET;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      cmd_ready_o <= 1'b1;
      tx_take_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o <= PTR_RESET;
      done_o <= 1'b0;
      nack_o <= 1'b0;
    end else begin
      tx_take_o <= 1'b0;
      rx_valid_o <= 1'b0;
      done_o <= 1'b0;
      if (state_reg == M_IDLE) begin
        if (cmd_valid_i && cmd_ready_o) begin
          cmd_ready_o <= 1'b0;
          nack_o <= 1'b0;
          read_reg <= cmd_read_i;
          sel_reg <= cmd_sel_i;
          ptr_reg <= cmd_ptr_i;
          left_reg <= cmd_len_i;
          step_reg <= P_ADDRW;
          txb_reg <= {SLAVE_ADDR_BASE[6:2], cmd_sel_i, DIR_WRITE, 1'b1};
          ph_reg <= 2'h0;
          state_reg <= M_START;
        end
      end else if (tick) begin
        ph_reg <= ph_reg + 2'h1;
        unique case (state_reg)
          M_START: begin
            // SCL only moves at phase 1 and 3, so a repeated start begins with SCL low
            unique case (ph_reg)
              2'h0: sda_oe_reg <= 1'b0;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b1;
              2'h3: begin
                scl_oe_reg <= 1'b1;
                bit_reg <= BIT_ZERO;
                state_reg <= M_BYTE;
              end
            endcase
          end
          M_BYTE: begin
            unique case (ph_reg)
              2'h0: sda_oe_reg <= !txb_reg[8];
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: rxb_reg <= {rxb_reg[7:0], sda_s};
              2'h3: begin
                scl_oe_reg <= 1'b1;
                txb_reg <= {txb_reg[7:0], 1'b1};
                bit_reg <= bit_reg + BIT_ONE;
                // Ninth pulse done: act on the acknowledge just sampled
                if (bit_reg == BYTE_BITS) begin
                  bit_reg <= BIT_ZERO;
                  if (step_reg == P_RDATA) begin
                    rx_data_o <= rxb_reg[8:1];
                    rx_valid_o <= 1'b1;
                    if (left_reg == LEN_LAST) begin
                      state_reg <= M_STOP;
                    end else begin
                      left_reg <= left_reg - BIT_ONE;
                      txb_reg <= {BYTE_RELEASED, left_reg == LEN_NEXT_LAST};
                    end
                  end else if (!ack) begin
                    nack_o <= 1'b1;
                    state_reg <= M_STOP;
                  end else begin
                    unique case (step_reg)
                      P_ADDRW: begin
                        step_reg <= P_PTR;
                        txb_reg <= {ptr_reg, 1'b1};
                      end
                      P_PTR: begin
                        if (read_reg == DIR_READ) begin
                          step_reg <= P_ADDRR;
                          txb_reg <= {SLAVE_ADDR_BASE[6:2], sel_reg, DIR_READ, 1'b1};
                          state_reg <= M_START;
                        end else begin
                          step_reg <= P_WDATA;
                          txb_reg <= {tx_data_i, 1'b1};
                          tx_take_o <= 1'b1;
                        end
                      end
                      P_WDATA: begin
                        if (left_reg == LEN_LAST) begin
                          state_reg <= M_STOP;
                        end else begin
                          left_reg <= left_reg - BIT_ONE;
                          txb_reg <= {tx_data_i, 1'b1};
                          tx_take_o <= 1'b1;
                        end
                      end
                      default: begin
                        step_reg <= P_RDATA;
                        txb_reg <= {BYTE_RELEASED, left_reg == LEN_LAST};
                      end
                    endcase
                  end
                end
              end
            endcase
          end
          M_STOP: begin
            unique case (ph_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b0;
              2'h3: begin
                done_o <= 1'b1;
                cmd_ready_o <= 1'b1;
                state_reg <= M_IDLE;
              end
            endcase
          end
          M_IDLE: state_reg <= M_IDLE;
        endcase
      end
    end
  end
endmodule : i2c_master_end

// >>> test/i2c_link_asserts.sv
// Concurrent checks on the two-wire link between the master end and the slave end
`timescale 1ns/1ps
module i2c_link_asserts (
  // Clock and reset
  input wire logic link_clk_i,
  input wire logic rstn_i,
  // Link signals
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_reg;
  logic sda_reg;
  logic [3:0] bit_cnt_reg;
  logic first_reg;
  logic rd_reg;
  logic busy_reg;
  logic rise;
  logic start;
  logic stop;

  // Wires are asynchronous here, but every edge is at least two link cycles apart
  assign rise = scl && !scl_reg;
  assign start = scl && scl_reg && sda_reg && !sda;
  assign stop = scl && scl_reg && !sda_reg && sda;

  always_ff @(posedge link_clk_i) begin
    scl_reg <= scl;
    sda_reg <= sda;
  end

  // Clock pulse count in the byte; the stop or repeated start pulse counts as 1 again
  always_ff @(posedge link_clk_i) begin
    if (!rstn_i || start) begin
      bit_cnt_reg <= 4'h0;
    end else if (rise) begin
      bit_cnt_reg <= (bit_cnt_reg == 4'h9) ? 4'h1 : bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!rstn_i) begin
      first_reg <= 1'b0;
      rd_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (start || stop) begin
      first_reg <= start;
      rd_reg <= 1'b0;
      busy_reg <= start;
    end else if (rise) begin
      first_reg <= first_reg && (bit_cnt_reg != 4'h9);
      rd_reg <= (first_reg && bit_cnt_reg == 4'h7) ? sda : rd_reg;
    end
  end

  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (!rstn_i);

  // Master transmits in the write phase, so it must leave the acknowledge pulse to the slave
  chk_master_release: assert property (scl && scl_reg && bit_cnt_reg == 4'h9 && !rd_reg |-> !m_sda_oe)
    else $error("master holds data in the slave acknowledge slot");
  chk_slave_drain: assert property (s_sda_oe |-> !s_sda_o)
    else $error("slave drives data high");
  chk_no_overlap: assert property (scl && scl_reg |-> !(m_sda_oe && s_sda_oe))
    else $error("both ends drive data while clock is high");
  chk_hold_high: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("slave changes data while clock is high");
  chk_ack_held: assert property (rise && s_sda_oe |-> s_sda_oe throughout (##[1:1000] !scl))
    else $error("slave low level not held over the high phase");
  chk_ack_slot: assert property (scl && scl_reg && s_sda_oe && !rd_reg |-> bit_cnt_reg == 4'h9)
    else $error("slave drives outside the acknowledge slot");
  chk_read_release: assert property (scl && scl_reg && rd_reg && !first_reg
    && bit_cnt_reg == 4'h9 |-> !s_sda_oe)
    else $error("slave holds data during the master acknowledge");
  chk_stop_frame: assert property (stop |-> bit_cnt_reg == 4'h1)
    else $error("stop not after a complete nine pulse byte");
  chk_start_frame: assert property (start |-> bit_cnt_reg <= 4'h1)
    else $error("start inside a byte");
  chk_idle_released: assert property (!busy_reg |-> !s_sda_oe)
    else $error("slave drives data while the bus is idle");
endmodule : i2c_link_asserts

// >>> test/led_driver_i2c_slave_port_tb_top.sv
// Bench joining the master end and the slave end over one link, with a register array model
`timescale 1ns/1ps
module led_driver_i2c_slave_port_tb_top import i2c_led_pkg::*; ;
  logic sys_clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [1:0] addr_sel_i = 2'h2;
  logic cmd_valid_i = 1'b0;
  logic cmd_read_i = 1'b0;
  logic [1:0] cmd_sel_i = 2'h0;
  logic [7:0] cmd_ptr_i = 8'h00;
  logic [3:0] cmd_len_i = 4'h1;
  logic [7:0] tx_data_i = 8'h00;
  logic reg_wr_o, reg_rd_o, cmd_ready_o, tx_take_o, rx_valid_o, done_o, nack_o, mon_ack, mon_first;
  logic [7:0] reg_addr_o, reg_wdata_o, reg_rdata_i, rx_data_o, mon_sh, mon_addr;
  logic [3:0] mon_cnt = 4'h0;
  logic [7:0] regs [0:255];
  logic [7:0] tx_bytes [0:1];
  logic [7:0] wr_addr_q [$];
  logic [7:0] wr_data_q [$];
  logic [7:0] rx_q [$];
  int tx_idx = 0;
  int errors = 0;
  int total_checks = 0;

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #1.3;
    forever #3 link_clk_i = ~link_clk_i;
  end

  i2c_link_if i2c_link_if_i ();
  i2c_slave_end i2c_slave_end_i (.sys_clk_i(sys_clk_i), .link_clk_i(link_clk_i), .rstn_i(rstn_i),
    .addr_sel_i(addr_sel_i), .bus(i2c_link_if_i), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o),
    .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_rdata_i(reg_rdata_i));
  i2c_master_end i2c_master_end_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .bus(i2c_link_if_i),
    .cmd_valid_i(cmd_valid_i), .cmd_read_i(cmd_read_i), .cmd_sel_i(cmd_sel_i), .cmd_ptr_i(cmd_ptr_i),
    .cmd_len_i(cmd_len_i), .cmd_ready_o(cmd_ready_o), .tx_data_i(tx_data_i), .tx_take_o(tx_take_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .done_o(done_o), .nack_o(nack_o));
  i2c_link_asserts i2c_link_asserts_i (.link_clk_i(link_clk_i), .rstn_i(rstn_i),
    .m_scl_o(i2c_link_if_i.m_scl_o), .m_scl_oe(i2c_link_if_i.m_scl_oe), .m_sda_o(i2c_link_if_i.m_sda_o),
    .m_sda_oe(i2c_link_if_i.m_sda_oe), .s_sda_o(i2c_link_if_i.s_sda_o), .s_sda_oe(i2c_link_if_i.s_sda_oe),
    .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda));

  // Read data is combinational, as the slave samples it in its read strobe cycle
  assign reg_rdata_i = regs[reg_addr_o];
  always @(posedge sys_clk_i) begin
    if (reg_wr_o === 1'b1) begin
      regs[reg_addr_o] <= reg_wdata_o;
      wr_addr_q.push_back(reg_addr_o);
      wr_data_q.push_back(reg_wdata_o);
    end
    if (rx_valid_o === 1'b1) begin
      rx_q.push_back(rx_data_o);
    end
    #1;
    if (tx_take_o === 1'b1) begin
      tx_idx++;
      tx_data_i = tx_bytes[tx_idx % 2];
    end
  end

  // Wire monitor: address byte and acknowledge bit of the last byte on the link
  always @(negedge i2c_link_if_i.sda) begin
    if (i2c_link_if_i.scl === 1'b1) begin
      mon_cnt = 4'h0;
      mon_first = 1'b1;
    end
  end
  always @(posedge i2c_link_if_i.scl) begin
    if (mon_cnt == 4'h9) begin
      mon_cnt = 4'h0;
      mon_first = 1'b0;
    end
    mon_cnt = mon_cnt + 4'h1;
    mon_sh = {mon_sh[6:0], i2c_link_if_i.sda};
    if (mon_cnt == 4'h8 && mon_first) mon_addr = mon_sh;
    if (mon_cnt == 4'h9) mon_ack = i2c_link_if_i.sda;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // Two-byte transfer; the bound covers the longest read with repeated start
  task automatic run_cmd(input logic rd, input logic [1:0] sel, input logic [7:0] ptr);
    int n;
    cmd_read_i = rd;
    cmd_sel_i = sel;
    cmd_ptr_i = ptr;
    tx_idx = 0;
    tx_data_i = tx_bytes[0];
    wr_addr_q.delete();
    wr_data_q.delete();
    rx_q.delete();
    cmd_valid_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    cmd_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 60000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n >= 60000) begin
      errors++;
      stop_test();
    end
  endtask : run_cmd

  task automatic test_bad_addr;
    tx_bytes[0] = 8'h5A;
    tx_bytes[1] = 8'hA5;
    run_cmd(DIR_WRITE, 2'h1, 8'h10);
    check(mon_addr, 8'h62);
    check({7'h00, mon_ack}, 8'h01);
    check({7'h00, nack_o}, 8'h01);
    check(8'(wr_addr_q.size()), 8'h00);
  endtask : test_bad_addr

  task automatic test_write_wrap;
    addr_sel_i = 2'h3;
    tx_bytes[0] = 8'hAB;
    tx_bytes[1] = 8'hCD;
    run_cmd(DIR_WRITE, 2'h3, 8'hFF);
    check(mon_addr, 8'h66);
    check({6'h00, nack_o, mon_ack}, 8'h00);
    check(8'(wr_addr_q.size()), 8'h02);
    check(wr_addr_q[0], 8'hFF);
    check(wr_data_q[0], 8'hAB);
    check(wr_addr_q[1], 8'h00);
    check(wr_data_q[1], 8'hCD);
  endtask : test_write_wrap

  task automatic test_read_wrap;
    run_cmd(DIR_READ, 2'h3, 8'hFF);
    check(mon_addr, 8'h67);
    check({6'h00, nack_o, mon_ack}, 8'h01);
    check(8'(rx_q.size()), 8'h02);
    check(rx_q[0], 8'hAB);
    check(rx_q[1], 8'hCD);
  endtask : test_read_wrap

  initial begin
    for (int i = 0; i < 256; i++) regs[i] = 8'h00;
    tx_bytes[0] = 8'h00;
    tx_bytes[1] = 8'h00;
    repeat (6) @(posedge sys_clk_i);
    #1;
    rstn_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    check({5'h00, cmd_ready_o, i2c_link_if_i.s_sda_oe, i2c_link_if_i.sda}, 8'h05);
    test_bad_addr();
    test_write_wrap();
    test_read_wrap();
    stop_test();
  end
endmodule : led_driver_i2c_slave_port_tb_top
